// >>> hw/fbt_pkg.sv
// Package for the fixed blanking teach logic
// Assumes a 50 MHz system clock and a fixed beam count per curtain
package fbt_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned BEAMS       = 32;  // Beams in the curtain
  localparam int unsigned MAX_REGIONS = 10;  // Blanked regions allowed
  localparam int unsigned RES_BEAMS   = 2;   // Resolution in beams
  localparam int unsigned CNT_W       = 28;  // Timer width

  // ****************************************
  // Timing
  // ****************************************
  localparam longint unsigned CLK_HZ        = 50000000;
  localparam longint unsigned PRESS_MIN_MS  = 150;   // Least press, 0.15 s
  localparam longint unsigned PRESS_MAX_MS  = 4000;  // Longest press, 4 s
  localparam longint unsigned GATE_MAX_MS   = 4000;  // Gate to interruption, 4 s
  localparam longint unsigned FLASH_MS      = 250;   // Indicator half period

  // Cycles for a time in milliseconds at a clock rate, rounded up
  function automatic longint unsigned ms_to_cyc(input longint unsigned ms,
                                                input longint unsigned hz);
    return (ms * hz + 999) / 1000;
  endfunction

  localparam longint unsigned PRESS_MIN_CYC = ms_to_cyc(PRESS_MIN_MS, CLK_HZ);
  localparam longint unsigned PRESS_MAX_CYC = ms_to_cyc(PRESS_MAX_MS, CLK_HZ);
  localparam longint unsigned GATE_MAX_CYC  = ms_to_cyc(GATE_MAX_MS, CLK_HZ);
  localparam longint unsigned FLASH_CYC     = ms_to_cyc(FLASH_MS, CLK_HZ);

  // ****************************************
  // Teach states
  // ****************************************
  typedef enum logic [1:0] {
    FBT_IDLE  = 2'b00,
    FBT_TEACH = 2'b01
  } fbt_state_t;

endpackage

// >>> hw/fbt_teach.sv
// Fixed blanking teach, mask and gating check logic
// Assumes beam, key and gating inputs synchronous to i_clk_sys
//
// Functional notes
// - At most ten blanked regions of adjacent beams
// - One synchronization beam must stay unblanked; only the taught mask is checked, tolerance can blank both
// - Regions spaced at least the resolution apart
// - Tolerance widens each region one beam per side
// - Valid first press starts teach, indicator flashes
// - Valid second press ends teach, stores objects
// - Indicator steady when any beam blanked
// - Indicator off when taught field was clear
// - Object size change over one beam aborts
// - Field interrupted within 4 s of gating
// - Faulty gating makes signal output flash
`timescale 1ns/10ps
module fbt_teach #(
  parameter longint unsigned CLK_HZ = fbt_pkg::CLK_HZ  // Clock rate behind the timing counts
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_sys_rst,
  input  wire logic                      i_teach_key,
  input  wire logic                      i_tolerance_en,
  input  wire logic [fbt_pkg::BEAMS-1:0] i_beam_blocked,
  input  wire logic                      i_gating_req,
  output logic [fbt_pkg::BEAMS-1:0]      o_blank_mask,
  output logic [fbt_pkg::BEAMS-1:0]      o_beam_eval,
  output logic                           o_teach_indicator,
  output logic                           o_teach_size_error_message,
  output logic                           o_signal_out
);

  localparam int unsigned B = fbt_pkg::BEAMS;

  // Timing counts at the clock rate in use
  localparam logic [fbt_pkg::CNT_W-1:0] PRESS_MIN_C =
    fbt_pkg::CNT_W'(fbt_pkg::ms_to_cyc(fbt_pkg::PRESS_MIN_MS, CLK_HZ));
  localparam logic [fbt_pkg::CNT_W-1:0] PRESS_MAX_C =
    fbt_pkg::CNT_W'(fbt_pkg::ms_to_cyc(fbt_pkg::PRESS_MAX_MS, CLK_HZ));
  localparam logic [fbt_pkg::CNT_W-1:0] GATE_MAX_C  =
    fbt_pkg::CNT_W'(fbt_pkg::ms_to_cyc(fbt_pkg::GATE_MAX_MS, CLK_HZ));
  localparam logic [fbt_pkg::CNT_W-1:0] FLASH_C     =
    fbt_pkg::CNT_W'(fbt_pkg::ms_to_cyc(fbt_pkg::FLASH_MS, CLK_HZ));

  // ****************************************
  // Helper functions
  // ****************************************

  // Count blocked beams
  function automatic logic [7:0] pop(input logic [B-1:0] v);
    logic [7:0] n;
    n = 8'h00;
    for (int i = 0; i < B; i++) begin
      n = n + {7'h00, v[i]};
    end
    return n;
  endfunction

  // Check region count, gap and sync beams
  function automatic logic mask_ok(input logic [B-1:0] m);
    logic [7:0] regions;
    logic [7:0] gap;
    logic       bad;
    logic       seen;
    regions = 8'h00;
    gap     = 8'h00;
    bad     = 1'b0;
    seen    = 1'b0;
    for (int i = 0; i < B; i++) begin
      if (m[i] && (i == 0 || !m[i-1])) begin
        regions = regions + 8'h01;
        if (seen && gap < 8'(fbt_pkg::RES_BEAMS)) begin
          bad = 1'b1;
        end
      end
      if (m[i]) begin
        seen = 1'b1;
        gap  = 8'h00;
      end else begin
        gap = gap + 8'h01;
      end
    end
    if (regions > 8'(fbt_pkg::MAX_REGIONS)) begin
      bad = 1'b1;
    end
    if (m[0] && m[B-1]) begin
      bad = 1'b1;
    end
    return !bad;
  endfunction

  // ****************************************
  // Key press timing
  // ****************************************
  logic                         key_d_r;
  logic                         key_d_nxt;
  logic [fbt_pkg::CNT_W-1:0]    press_cnt_r;
  logic [fbt_pkg::CNT_W-1:0]    press_cnt_nxt;
  logic                         valid_press;

  // Measure hold time, flag valid release
  always_comb begin
    key_d_nxt     = i_teach_key;
    press_cnt_nxt = press_cnt_r;
    if (i_teach_key && !key_d_r) begin
      press_cnt_nxt = '0;
    end else if (i_teach_key && press_cnt_r != '1) begin
      press_cnt_nxt = press_cnt_r + 1'b1;
    end
    valid_press = !i_teach_key && key_d_r
                  && (press_cnt_r + 1'b1) >= PRESS_MIN_C
                  && (press_cnt_r + 1'b1) <= PRESS_MAX_C;
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      key_d_r     <= 1'b0;
      press_cnt_r <= '0;
    end else begin
      key_d_r     <= key_d_nxt;
      press_cnt_r <= press_cnt_nxt;
    end
  end

  // ****************************************
  // Teach state and stored mask
  // ****************************************
  fbt_pkg::fbt_state_t  state_r;
  fbt_pkg::fbt_state_t  state_nxt;
  logic [B-1:0]         taught_r;
  logic [B-1:0]         taught_nxt;
  logic [7:0]           ref_size_r;
  logic [7:0]           ref_size_nxt;
  logic                 err_r;
  logic                 err_nxt;
  logic [7:0]           cur_size;

  // Teach sequence with size stability check
  always_comb begin
    state_nxt    = state_r;
    taught_nxt   = taught_r;
    ref_size_nxt = ref_size_r;
    err_nxt      = err_r;
    cur_size     = pop(i_beam_blocked);
    case (state_r)
      fbt_pkg::FBT_IDLE: begin
        if (valid_press) begin
          state_nxt    = fbt_pkg::FBT_TEACH;
          ref_size_nxt = cur_size;
          err_nxt      = 1'b0;
        end
      end
      fbt_pkg::FBT_TEACH: begin
        if ((cur_size > ref_size_r + 8'h01) || (cur_size + 8'h01 < ref_size_r)) begin
          state_nxt = fbt_pkg::FBT_IDLE;
          err_nxt   = 1'b1;
        end else if (valid_press) begin
          state_nxt = fbt_pkg::FBT_IDLE;
          if (mask_ok(i_beam_blocked)) begin
            taught_nxt = i_beam_blocked;
          end else begin
            err_nxt = 1'b1;
          end
        end
      end
      default: state_nxt = fbt_pkg::FBT_IDLE;
    endcase
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_r    <= fbt_pkg::FBT_IDLE;
      taught_r   <= '0;
      ref_size_r <= 8'h00;
      err_r      <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      taught_r   <= taught_nxt;
      ref_size_r <= ref_size_nxt;
      err_r      <= err_nxt;
    end
  end

  // ****************************************
  // Gating check and flasher
  // ****************************************
  logic [fbt_pkg::CNT_W-1:0] gate_cnt_r;
  logic [fbt_pkg::CNT_W-1:0] gate_cnt_nxt;
  logic                      gate_fault_r;
  logic                      gate_fault_nxt;
  logic                      gate_seen_r;
  logic                      gate_seen_nxt;
  logic [fbt_pkg::CNT_W-1:0] flash_cnt_r;
  logic [fbt_pkg::CNT_W-1:0] flash_cnt_nxt;
  logic                      flash_r;
  logic                      flash_nxt;
  logic [B-1:0]              eff_mask;
  logic                      field_int;

  // Apply tolerance, evaluate field, time gating
  always_comb begin
    eff_mask = taught_r;
    if (i_tolerance_en) begin
      eff_mask = taught_r | (taught_r << 1) | (taught_r >> 1);
    end
    field_int      = |(i_beam_blocked & ~eff_mask);
    gate_cnt_nxt   = gate_cnt_r;
    gate_fault_nxt = gate_fault_r;
    gate_seen_nxt  = gate_seen_r;
    if (!i_gating_req) begin
      gate_cnt_nxt   = '0;
      gate_seen_nxt  = 1'b0;
      gate_fault_nxt = 1'b0;
    end else if (field_int) begin
      gate_seen_nxt = 1'b1;
    end else if (!gate_seen_r) begin
      gate_cnt_nxt = gate_cnt_r + 1'b1;
      if (gate_cnt_r + 1'b1 >= GATE_MAX_C) begin
        gate_fault_nxt = 1'b1;
      end
    end
    flash_cnt_nxt = flash_cnt_r + 1'b1;
    flash_nxt     = flash_r;
    if (flash_cnt_r + 1'b1 >= FLASH_C) begin
      flash_cnt_nxt = '0;
      flash_nxt     = !flash_r;
    end
  end

  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      gate_cnt_r   <= '0;
      gate_fault_r <= 1'b0;
      gate_seen_r  <= 1'b0;
      flash_cnt_r  <= '0;
      flash_r      <= 1'b0;
    end else begin
      gate_cnt_r   <= gate_cnt_nxt;
      gate_fault_r <= gate_fault_nxt;
      gate_seen_r  <= gate_seen_nxt;
      flash_cnt_r  <= flash_cnt_nxt;
      flash_r      <= flash_nxt;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_blank_mask               <= '0;
      o_beam_eval                <= '0;
      o_teach_indicator          <= 1'b0;
      o_teach_size_error_message <= 1'b0;
      o_signal_out               <= 1'b0;
    end else begin
      o_blank_mask               <= eff_mask;
      o_beam_eval                <= i_beam_blocked & ~eff_mask;
      o_teach_indicator          <= (state_r == fbt_pkg::FBT_TEACH) ? flash_r
                                    : (|taught_r);
      o_teach_size_error_message <= err_r;
      o_signal_out               <= i_gating_req && (!gate_fault_r || flash_r);
    end
  end

endmodule

// >>> bench/fbt_teach_asserts.sv
// Checker bound onto the ports of the teach logic
// Assumes one clock domain and the counts of fbt_pkg
`timescale 1ns/10ps
module fbt_teach_asserts #(
  parameter longint unsigned CLK_HZ = fbt_pkg::CLK_HZ  // Clock rate behind the timing counts
) (
  input wire logic                      i_clk_sys,
  input wire logic                      i_sys_rst,
  input wire logic                      i_teach_key,
  input wire logic                      i_tolerance_en,
  input wire logic [fbt_pkg::BEAMS-1:0] i_beam_blocked,
  input wire logic                      i_gating_req,
  input wire logic [fbt_pkg::BEAMS-1:0] o_blank_mask,
  input wire logic [fbt_pkg::BEAMS-1:0] o_beam_eval,
  input wire logic                      o_teach_indicator,
  input wire logic                      o_teach_size_error_message,
  input wire logic                      o_signal_out
);
  localparam int unsigned PRESS_MIN_C = int'(fbt_pkg::ms_to_cyc(fbt_pkg::PRESS_MIN_MS, CLK_HZ));
  localparam int unsigned GATE_C      = int'(fbt_pkg::ms_to_cyc(fbt_pkg::GATE_MAX_MS, CLK_HZ));
  int unsigned hold_r, hold_nxt, gate_r, gate_nxt;

  // Cycles the key and the gating request have stayed high
  always_comb begin
    hold_nxt = i_teach_key ? hold_r + 1 : 0;
    gate_nxt = i_gating_req ? gate_r + 1 : 0;
  end
  always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      hold_r <= 0;
      gate_r <= 0;
    end else begin
      hold_r <= hold_nxt;
      gate_r <= gate_nxt;
    end
  end

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  // Release of a press too short to count, then a quiet mask
  sequence short_rel; $fell(i_teach_key) && hold_r < PRESS_MIN_C; endsequence
  sequence mask_hold; $stable(o_blank_mask) [*3]; endsequence

  chk_rst_clear: assert property ($fell(i_sys_rst) |-> o_blank_mask == '0 && !o_signal_out)
    else $error("outputs not clear after reset");
  chk_eval_masked: assert property ((o_beam_eval & o_blank_mask) == '0)
    else $error("masked beam evaluated");
  chk_eval_follow: assert property (!$past(i_sys_rst) && $stable(o_blank_mask) |->
    o_beam_eval == ($past(i_beam_blocked) & ~o_blank_mask))
    else $error("evaluated beams wrong");
  chk_sync_kept: assert property (!i_tolerance_en && !$past(i_tolerance_en) |->
    !(o_blank_mask[0] && o_blank_mask[fbt_pkg::BEAMS-1]))
    else $error("both sync beams blanked");
  chk_short_ignore: assert property (short_rel |=> mask_hold)
    else $error("short press changed mask");
  chk_gate_rise: assert property ($rose(i_gating_req) |=> o_signal_out)
    else $error("signal output missed gating");
  chk_gate_drop: assert property (!i_gating_req |=> !o_signal_out)
    else $error("signal output high without gating");
  chk_gate_hold: assert property (i_gating_req && gate_r < GATE_C |=> o_signal_out)
    else $error("gating fault raised too early");
  chk_err_keep: assert property ($rose(o_teach_size_error_message)
    && $past(i_tolerance_en) == $past(i_tolerance_en, 2) |-> $stable(o_blank_mask))
    else $error("mask changed by a failed teach");
endmodule

bind fbt_teach fbt_teach_asserts #(.CLK_HZ(CLK_HZ)) fbt_teach_asserts_i (.i_clk_sys, .i_sys_rst,
  .i_teach_key,
  .i_tolerance_en, .i_beam_blocked, .i_gating_req, .o_blank_mask, .o_beam_eval,
  .o_teach_indicator, .o_teach_size_error_message, .o_signal_out);

// >>> bench/fbt_operator.sv
// Model of the operator teach key and the gating controller
// Assumes the bench calls its tasks; pins change at falling edges
`timescale 1ns/10ps
module fbt_operator (
  input  wire logic i_clk_sys,
  output logic      o_teach_key,
  output logic      o_gating_req
);
  // Key released and gating idle from the start
  initial begin
    o_teach_key  = 1'b0;
    o_gating_req = 1'b0;
  end

  // Key held for n cycles, then released
  task automatic press(input int n);
    @(negedge i_clk_sys) o_teach_key = 1'b1;
    repeat (n) @(negedge i_clk_sys);
    o_teach_key = 1'b0;
  endtask

  // Gating request set to the given level at the next falling edge
  task automatic gate(input logic on);
    @(negedge i_clk_sys) o_gating_req = on;
  endtask
endmodule

// >>> bench/fbt_teach_tb.sv
// Self-checking bench of the teach logic against a bench model
// Assumes the operator model drives the key and the gating request
`timescale 1ns/10ps
module fbt_teach_tb;
  typedef logic [fbt_pkg::BEAMS-1:0] fbt_beams_t;
  logic       clk, rst, tol, key, req, ind, err, sig;
  fbt_beams_t blk, mask, ev, exp_m;
  int         n_mismatch, checked, cyc, r;
  int         tg;
  logic       s0;
  // Scaled clock rate so each timing window fits a short run
  localparam longint unsigned SIM_HZ = 10000;
  localparam int PRESS_C = int'(fbt_pkg::PRESS_MIN_MS * SIM_HZ / 1000) + 100;
  localparam int GATE_C  = int'(fbt_pkg::GATE_MAX_MS * SIM_HZ / 1000);
  localparam int FLASH_C = int'(fbt_pkg::FLASH_MS * SIM_HZ / 1000);

  fbt_teach #(.CLK_HZ(SIM_HZ)) fbt_teach_i (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_teach_key(key),
    .i_tolerance_en(tol), .i_beam_blocked(blk), .i_gating_req(req),
    .o_blank_mask(mask), .o_beam_eval(ev), .o_teach_indicator(ind),
    .o_teach_size_error_message(err), .o_signal_out(sig));
  fbt_operator fbt_operator_i (.i_clk_sys(clk), .o_teach_key(key), .o_gating_req(req));

  // Clock of 20 ns
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input fbt_beams_t seen, input fbt_beams_t want);
    checked++;
    if (seen !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic summarize();
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Taught mask as applied, one beam wider each side with tolerance
  function automatic fbt_beams_t widen(input fbt_beams_t m);
    return tol ? (m | m << 1 | m >> 1) : m;
  endfunction

  // Whether a pattern may be stored as blanked regions
  function automatic bit valid(input fbt_beams_t p);
    int n, last;
    bit v;
    n = 0;
    last = -9;
    v = !(p[0] && p[fbt_pkg::BEAMS-1]);
    for (int b = 0; b < fbt_pkg::BEAMS; b++) begin
      if (p[b] && b - last > 1) begin
        n++;
        if (last >= 0 && b - last - 1 < fbt_pkg::RES_BEAMS) v = 1'b0;
      end
      if (p[b]) last = b;
    end
    return v && n <= fbt_pkg::MAX_REGIONS;
  endfunction

  // Teach with a short ignored press after the first; the second press is given only when the size stays within one beam
  task automatic teach(input fbt_beams_t p0, input fbt_beams_t p1);
    int d;
    d = $countones(p1) - $countones(p0);
    tol = 1'($urandom_range(1, 0));
    blk = p0;
    fbt_operator_i.press(PRESS_C);
    repeat (4) @(negedge clk);
    check(fbt_beams_t'(err), '0);
    fbt_operator_i.press($urandom_range(400, 1));
    blk = p1;
    repeat (4) @(negedge clk);
    if (d > 1 || d < -1) begin
      check(fbt_beams_t'(err), fbt_beams_t'(1));
    end else begin
      fbt_operator_i.press(PRESS_C);
      repeat (4) @(negedge clk);
      if (valid(p1)) exp_m = p1;
      check(fbt_beams_t'(err), fbt_beams_t'(!valid(p1)));
      check(fbt_beams_t'(ind), fbt_beams_t'(exp_m != '0));
    end
    check(mask, widen(exp_m));
    check(ev, blk & ~widen(exp_m));
  endtask

  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      summarize();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    tol = 1'b0;
    blk = '0;
    exp_m = '0;
    n_mismatch = 0;
    checked = 0;
    cyc = 0;
    r = $urandom(76088);
    repeat (5) @(negedge clk);
    rst = 1'b0;
    fbt_operator_i.press($urandom_range(400, 1));
    r = $urandom_range(21, 2);
    teach(fbt_beams_t'(4'hf) << r, fbt_beams_t'(5'h1f) << r);
    teach(32'h8000_0001, 32'h8000_0001);
    teach(32'h0000_0014, 32'h0000_0014);
    teach(32'h9249_2492, 32'h9249_2492);
    teach(32'h1249_2492, 32'h1249_2492);
    teach(32'h0000_0f00, 32'h0000_0000);
    teach('0, '0);
    blk = fbt_beams_t'($urandom) | 32'h0000_0100;
    fbt_operator_i.gate(1'b1);
    repeat (3) @(negedge clk);
    check(fbt_beams_t'(sig), fbt_beams_t'(1));
    fbt_operator_i.gate(1'b0);
    repeat (3) @(negedge clk);
    check(fbt_beams_t'(sig), '0);
    // Clear field under gating: steady high, then flashing past the limit
    blk = '0;
    fbt_operator_i.gate(1'b1);
    repeat (GATE_C - 100) @(negedge clk);
    check(fbt_beams_t'(sig), fbt_beams_t'(1));
    repeat (200) @(negedge clk);
    tg = 0;
    s0 = sig;
    repeat (2 * FLASH_C) begin
      @(negedge clk);
      if (sig !== s0) tg++;
      s0 = sig;
    end
    check(fbt_beams_t'(tg), fbt_beams_t'(2));
    fbt_operator_i.gate(1'b0);
    repeat (3) @(negedge clk);
    check(fbt_beams_t'(sig), '0);
    summarize();
  end
endmodule
